// >>> esq_pkg.sv
package esq_pkg;

  // ----------------------------------------------------------------
  // Sizes and limits
  // ----------------------------------------------------------------
  localparam int          STEPS       = 16;
  localparam int          NOUT        = 16;
  localparam int          CNT_W       = 14;
  localparam int          STEP_W      = 5;
  localparam int          EV_W        = 5;
  localparam int          ADR_W       = 9;
  localparam logic [13:0] CPS_MAX     = 14'd9999;
  localparam logic [13:0] TB_MAX      = 14'd9999;
  localparam logic [4:0]  PRESET_MIN  = 5'd1;
  localparam logic [4:0]  PRESET_MAX  = 5'd16;
  localparam logic [7:0]  BASE_MAX    = 8'd124;

  // ----------------------------------------------------------------
  // Timing: one timebase unit is one hundredth of a second
  // ----------------------------------------------------------------
  localparam int          UNIT_NS     = 10000000;
  localparam int          CLK_NS      = 100;
  localparam int          UNIT_CYC    = UNIT_NS / CLK_NS;

  // ----------------------------------------------------------------
  // Register byte offsets and step-table block selects
  // ----------------------------------------------------------------
  localparam logic [8:0]  OFF_CTRL    = 9'h000;
  localparam logic [8:0]  OFF_TB      = 9'h004;
  localparam logic [8:0]  OFF_PRE     = 9'h008;
  localparam logic [8:0]  OFF_CNT     = 9'h00c;
  localparam logic [8:0]  OFF_TMR     = 9'h010;
  localparam logic [8:0]  OFF_STEP    = 9'h014;
  localparam logic [8:0]  OFF_BASE    = 9'h018;
  localparam logic [8:0]  OFF_OUT     = 9'h01c;
  localparam logic [2:0]  REG_CPS     = 3'h1;
  localparam logic [2:0]  REG_PAT     = 3'h2;
  localparam logic [2:0]  REG_MSK     = 3'h3;
  localparam logic [2:0]  REG_EVT     = 3'h4;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int          B_START     = 0;
  localparam int          B_JOG       = 1;
  localparam int          B_RST       = 2;
  localparam int          B_RUN       = 3;
  localparam int          B_MASK      = 4;
  localparam int          CTRL_W      = 5;
  localparam int          B_DONE      = 31;
  localparam int          B_EV_USE    = 4;
  localparam logic [4:0]  CTRL_RST    = 5'h00;
  localparam logic [15:0] MASK_RST    = 16'hffff;
  localparam logic [15:0] PAT_RST     = 16'h0000;
  localparam logic [4:0]  EVT_RST     = 5'h00;

  typedef enum logic [1:0] {ST_PROG, ST_RUN, ST_DONE} esq_state_e;

endpackage

// >>> esq_tb_if.sv
`timescale 1ns/1ps
// Link between the step sequencer and its timebase counter.
interface esq_tb_if;
  logic        enable;
  logic        clear;
  logic [13:0] timebase;
  logic        pulse;
  logic [13:0] timer_val;
  modport seq (output enable, output clear, output timebase, input pulse, input timer_val);
  modport gen (input enable, input clear, input timebase, output pulse, output timer_val);
endinterface

// >>> esq_timebase.sv
`timescale 1ns/1ps
// Divides the clock into hundredths of a second, then into counts of timebase units.
module esq_timebase #(
  parameter int UNIT_CYC = esq_pkg::UNIT_CYC
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic nrst,
  // Sequencer side.
  esq_tb_if.gen    tb
);
  import esq_pkg::*;

  // Elaboration refuses a prescaler that the 24-bit unit counter cannot hold.
  if (UNIT_CYC < 2 || UNIT_CYC > 2**24) begin : g_bad_unit
    $error("UNIT_CYC out of range");
  end

  logic [23:0] unit_r;
  logic [13:0] sub_r;
  logic        pulse_r;
  logic        unit_end;

  assign unit_end     = tb.enable && (unit_r == 24'(UNIT_CYC - 1));
  assign tb.pulse     = pulse_r;
  assign tb.timer_val = sub_r;

  // Hundredth prescaler; it freezes while disabled so a paused step keeps its phase.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      unit_r <= 24'h000000;
    end else if (tb.clear || unit_end) begin
      unit_r <= 24'h000000;
    end else if (tb.enable) begin
      unit_r <= unit_r + 24'h000001;
    end
  end

  // One count lasts timebase units; a zero timebase is served as one unit.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sub_r   <= 14'h0000;
      pulse_r <= 1'b0;
    end else begin
      pulse_r <= 1'b0;
      if (tb.clear) begin
        sub_r <= 14'h0000;
      end else if (unit_end) begin
        if (sub_r + 14'h0001 >= tb.timebase) begin
          sub_r   <= 14'h0000;
          pulse_r <= 1'b1;
        end else begin
          sub_r <= sub_r + 14'h0001;
        end
      end
    end
  end

  a_pulse_single: assert property (@(posedge ref_clk) disable iff (!nrst)
    pulse_r |=> !pulse_r) else $error("count pulse longer than one cycle");
  a_pulse_cause: assert property (@(posedge ref_clk) disable iff (!nrst)
    $rose(pulse_r) |-> $past(unit_end) && !$past(tb.clear)) else $error("count pulse without unit end");

endmodule

// >>> esq_event_step_sequencer.sv
// Local design decisions: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
module esq_event_step_sequencer #(
  parameter int UNIT_CYC = esq_pkg::UNIT_CYC
) (
  // Clock and reset.
  input  wire logic                       ref_clk,
  input  wire logic                       nrst,
  // Wishbone classic slave.
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [esq_pkg::ADR_W-1:0]  wb_adr_i,
  input  wire logic [3:0]                 wb_sel_i,
  input  wire logic [31:0]                wb_dat_i,
  output logic      [31:0]                wb_dat_o,
  output logic                            wb_ack_o,
  // Event contacts and outputs.
  input  wire logic [esq_pkg::STEPS-1:0]  event_in,
  output logic      [esq_pkg::NOUT-1:0]   drum_out
);
  import esq_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [CTRL_W-1:0] ctrl_r;
  logic [13:0]       tb_r;
  logic [4:0]        preset_r;
  logic [7:0]        base_r;
  logic [13:0]       cps_r [STEPS];
  logic [15:0]       pat_r [STEPS];
  logic [15:0]       msk_r [STEPS];
  logic [EV_W-1:0]   evt_r [STEPS];
  logic [15:0]       ev_s1_r, ev_s2_r, ev_s3_r, ev_r;
  logic              jog_d_r, run_d_r;
  esq_state_e        state_r;
  logic [STEP_W-1:0] step_r;
  logic [CNT_W-1:0]  cnt_r;
  logic              done_r;
  logic              ack_r;
  logic [31:0]       dat_r;
  logic [15:0]       out_r;

  logic [3:0]        idx;
  logic              wr_go, rd_go, jog_rise, run_rise, rst_c, start_c, ev_ok, at_end, adv, load;
  logic [31:0]       wdat;
  logic [15:0]       out_nxt;
  logic [3:0]        tidx;

  esq_tb_if tb ();

  esq_timebase #(.UNIT_CYC(UNIT_CYC)) u_tb (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .tb      (tb.gen)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Byte-lane merge of a write into an existing word.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Step numbers run from one; the tables are indexed from zero.
  function automatic logic [3:0] step2idx(input logic [STEP_W-1:0] s);
    return 4'(s - 5'd1);
  endfunction

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // One wait state: ack rises the cycle after the request and falls after one cycle.
  assign wr_go    = wb_cyc_i && wb_stb_i && wb_we_i && !ack_r;
  assign rd_go    = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_r;
  assign tidx     = wb_adr_i[5:2];
  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign drum_out = out_r;

  // Sequencer control terms, all from registered state: control bits, step, count and synchronised events.
  assign idx      = step2idx(step_r);
  assign start_c  = ctrl_r[B_START];
  assign rst_c    = ctrl_r[B_RST];
  assign jog_rise = ctrl_r[B_JOG] && !jog_d_r;
  assign run_rise = ctrl_r[B_RUN] && !run_d_r;
  assign ev_ok    = !evt_r[idx][B_EV_USE] || ev_r[evt_r[idx][3:0]];
  assign at_end   = start_c && ev_ok && (cnt_r == cps_r[idx]);
  assign adv      = (state_r == ST_RUN) && !rst_c && !run_rise && (jog_rise || at_end);
  assign load     = rst_c || run_rise;

  // Timebase is gated by start and by the step's event.
  assign tb.enable   = (state_r == ST_RUN) && start_c && ev_ok && !adv && !load;
  assign tb.clear    = adv || load;
  assign tb.timebase = tb_r;

  // Pattern for the current step, masked when masking is selected.
  assign out_nxt = pat_r[idx] & (ctrl_r[B_MASK] ? msk_r[idx] : 16'hffff);

  // ----------------------------------------------------------------
  // Bus acknowledge and read data
  // ----------------------------------------------------------------
  // Unmapped addresses answer with zero data, so a stray read never hangs the master.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ack_r <= 1'b0;
      dat_r <= 32'h00000000;
    end else begin
      ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
      if (rd_go) begin
        dat_r <= 32'h00000000;
        case (wb_adr_i)
          OFF_CTRL: dat_r <= 32'(ctrl_r);
          OFF_TB:   dat_r <= 32'(tb_r);
          OFF_PRE:  dat_r <= 32'(preset_r);
          OFF_CNT:  dat_r <= {done_r, 17'h00000, cnt_r};
          OFF_TMR:  dat_r <= 32'(tb.timer_val);
          OFF_STEP: dat_r <= 32'(step_r);
          OFF_BASE: dat_r <= 32'(base_r);
          OFF_OUT:  dat_r <= 32'(out_r);
          default: begin
            case (wb_adr_i[8:6])
              REG_CPS: dat_r <= 32'(cps_r[tidx]);
              REG_PAT: dat_r <= 32'(pat_r[tidx]);
              REG_MSK: dat_r <= 32'(msk_r[tidx]);
              REG_EVT: dat_r <= 32'(evt_r[tidx]);
              default: dat_r <= 32'h00000000;
            endcase
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Write data merged into the addressed word, so the range checks see the whole new value.
  always_comb begin
    case (wb_adr_i)
      OFF_TB:   wdat = merge(32'(tb_r), wb_dat_i, wb_sel_i);
      OFF_PRE:  wdat = merge(32'(preset_r), wb_dat_i, wb_sel_i);
      OFF_BASE: wdat = merge(32'(base_r), wb_dat_i, wb_sel_i);
      default:  wdat = merge(32'(cps_r[tidx]), wb_dat_i, wb_sel_i);
    endcase
  end

  // Out-of-range values are dropped rather than clipped; status counters are read only.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_r   <= CTRL_RST;
      tb_r     <= 14'h0000;
      preset_r <= PRESET_MIN;
      base_r   <= 8'h00;
    end else if (wr_go) begin
      case (wb_adr_i)
        OFF_CTRL: ctrl_r <= CTRL_W'(merge(32'(ctrl_r), wb_dat_i, wb_sel_i));
        OFF_TB: begin
          if (wdat <= 32'(TB_MAX)) begin
            tb_r <= wdat[13:0];
          end
        end
        OFF_PRE: begin
          if (wdat >= 32'(PRESET_MIN) && wdat <= 32'(PRESET_MAX)) begin
            preset_r <= wdat[4:0];
          end
        end
        OFF_BASE: begin
          if (wdat <= 32'(BASE_MAX)) begin
            base_r <= wdat[7:0];
          end
        end
        default: ;
      endcase
    end
  end

  // Step tables; everything starts blank and masks start fully open.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < STEPS; i++) begin
        cps_r[i] <= 14'h0000;
        pat_r[i] <= PAT_RST;
        msk_r[i] <= MASK_RST;
        evt_r[i] <= EVT_RST;
      end
    end else if (wr_go) begin
      case (wb_adr_i[8:6])
        REG_CPS: begin
          if (wdat <= 32'(CPS_MAX)) begin
            cps_r[tidx] <= wdat[13:0];
          end
        end
        REG_PAT: pat_r[tidx] <= 16'(merge(32'(pat_r[tidx]), wb_dat_i, wb_sel_i));
        REG_MSK: msk_r[tidx] <= 16'(merge(32'(msk_r[tidx]), wb_dat_i, wb_sel_i));
        REG_EVT: evt_r[tidx] <= EV_W'(merge(32'(evt_r[tidx]), wb_dat_i, wb_sel_i));
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Event input synchroniser
  // ----------------------------------------------------------------
  // Three stages; a bit changes only once the second and third agree, which rejects one-cycle glitches.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ev_s1_r <= 16'h0000;
      ev_s2_r <= 16'h0000;
      ev_s3_r <= 16'h0000;
      ev_r    <= 16'h0000;
    end else begin
      ev_s1_r <= event_in;
      ev_s2_r <= ev_s1_r;
      ev_s3_r <= ev_s2_r;
      ev_r    <= (ev_s2_r & ev_s3_r) | (ev_r & (ev_s2_r | ev_s3_r));
    end
  end

  // ----------------------------------------------------------------
  // Step sequencer
  // ----------------------------------------------------------------
  // Edge memories for jog and the run mode bit.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      jog_d_r <= 1'b0;
      run_d_r <= 1'b0;
    end else begin
      jog_d_r <= ctrl_r[B_JOG];
      run_d_r <= ctrl_r[B_RUN];
    end
  end

  // Reset wins over everything, then mode entry, then jog and count advance.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_PROG;
      step_r  <= PRESET_MIN;
      cnt_r   <= 14'h0000;
      done_r  <= 1'b0;
    end else if (!ctrl_r[B_RUN]) begin
      state_r <= ST_PROG;
      if (rst_c) begin
        step_r <= preset_r;
        cnt_r  <= 14'h0000;
        done_r <= 1'b0;
      end
    end else if (load) begin
      state_r <= ST_RUN;
      step_r  <= preset_r;
      cnt_r   <= 14'h0000;
      done_r  <= 1'b0;
    end else begin
      case (state_r)
        ST_RUN: begin
          if (adv) begin
            cnt_r <= 14'h0000;
            if (step_r == PRESET_MAX) begin
              state_r <= ST_DONE;
              done_r  <= 1'b1;
            end else begin
              step_r <= step_r + 5'd1;
            end
          end else if (tb.pulse && tb.enable) begin
            cnt_r <= cnt_r + 14'h0001;
          end
        end
        ST_DONE: ;
        ST_PROG: state_r <= ST_PROG;  // Not reached: reset clears the run bit and each rise of it loads; wait for a new edge.
        default: state_r <= ST_PROG;
      endcase
    end
  end

  // Outputs follow the current step every clock, also outside run mode.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      out_r <= 16'h0000;
    end else begin
      out_r <= out_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_quiet;
    !wr_go ##1 !wr_go;
  endsequence

  a_timer_start: assert property (@(posedge ref_clk) disable iff (!nrst)
    tb.enable |-> start_c && state_r == ST_RUN) else $error("timer runs without start");
  a_count_event: assert property (@(posedge ref_clk) disable iff (!nrst)
    (cnt_r == $past(cnt_r) + 14'h0001) |-> $past(ev_ok) && $past(start_c)) else $error("count without event");
  a_count_limit: assert property (@(posedge ref_clk) disable iff (!nrst)
    cnt_r <= CPS_MAX) else $error("count above limit");
  a_step_next: assert property (@(posedge ref_clk) disable iff (!nrst)
    (ctrl_r[B_RUN] && !load && state_r == ST_RUN && at_end && step_r != PRESET_MAX)
    |=> step_r == $past(step_r) + 5'd1 && cnt_r == 14'h0000) else $error("step did not advance");
  a_jog_step: assert property (@(posedge ref_clk) disable iff (!nrst)
    (ctrl_r[B_RUN] && !load && state_r == ST_RUN && jog_rise && step_r != PRESET_MAX)
    |=> step_r == $past(step_r) + 5'd1) else $error("jog did not advance");
  a_done_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
    (state_r == ST_DONE && !rst_c && ctrl_r[B_RUN]) |=> $stable(step_r) && done_r) else $error("done not held");
  a_reset_load: assert property (@(posedge ref_clk) disable iff (!nrst)
    rst_c |=> step_r == $past(preset_r) && !done_r) else $error("reset did not load preset");
  a_run_entry: assert property (@(posedge ref_clk) disable iff (!nrst)
    run_rise |=> state_r == ST_RUN && step_r == $past(preset_r)) else $error("run entry missed preset");
  a_preset_range: assert property (@(posedge ref_clk) disable iff (!nrst)
    preset_r >= PRESET_MIN && preset_r <= PRESET_MAX) else $error("preset out of range");
  // With no table write and a steady step and control word, the outputs show the pattern, ANDed with the mask when masking is selected.
  a_output_mask: assert property (@(posedge ref_clk) disable iff (!nrst)
    s_quiet ##0 $stable(step_r) ##0 $stable(ctrl_r)
    |-> out_r == (pat_r[idx] & (ctrl_r[B_MASK] ? msk_r[idx] : 16'hffff))) else $error("outputs differ from step");
  a_done_last: assert property (@(posedge ref_clk) disable iff (!nrst)
    $rose(done_r) |-> step_r == PRESET_MAX) else $error("done before last step");

endmodule

// >>> esq_event_src.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Event contact source standing in for the controlling program
// ----------------------------------------------------------------
module esq_event_src (
  // Clock and reset.
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  // Requested contact levels from the bench.
  input  wire logic [15:0] ev_req,
  // Contacts seen by the sequencer.
  output logic      [15:0] ev_out
);
  // Contacts change one clock after the request, clean and bounce free.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ev_out <= 16'h0000;
    end else begin
      ev_out <= ev_req;
    end
  end
endmodule

// >>> masked_event_step_sequencer_tb.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Self-checking bench for the event step sequencer
// ----------------------------------------------------------------
module masked_event_step_sequencer_tb;
  import esq_pkg::*;
  logic        ref_clk;
  logic        nrst;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [8:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [15:0] ev_req;
  logic [15:0] event_in;
  logic [15:0] drum_out;
  logic [31:0] q;
  int          err_total;
  int          compares;
  int          cycles;

  // Short unit so a count lasts four clocks instead of ten milliseconds.
  esq_event_step_sequencer #(.UNIT_CYC(4)) uut (
    .ref_clk(ref_clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .event_in(event_in), .drum_out(drum_out)
  );

  esq_event_src src (.ref_clk(ref_clk), .nrst(nrst), .ev_req(ev_req), .ev_out(event_in));

  // Clock at 100 ns period.
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // Timeout guards against a bus that never acknowledges.
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total = err_total + 1;
      finish_test();
    end
  end

  task automatic finish_test();
    if (err_total == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares = compares + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Classic single cycle: hold everything until ack is sampled high.
  task automatic wb(input logic we, input logic [8:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_sel_i <= 4'hf;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge ref_clk);
    while (wb_ack_o !== 1'b1) @(posedge ref_clk);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  task automatic rd_chk(input string name, input logic [8:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0000_0000);
    chk(name, exp, q);
  endtask

  // Reset values and an unmapped read.
  task automatic t_reset_vals();
    rd_chk("preset", OFF_PRE, 32'h0000_0001);
    rd_chk("step", OFF_STEP, 32'h0000_0001);
    rd_chk("count", OFF_CNT, 32'h0000_0000);
    rd_chk("mask0", 9'h0c0, 32'h0000_ffff);
    rd_chk("event0", 9'h100, 32'h0000_0000);
    rd_chk("unmapped", 9'h1fc, 32'h0000_0000);
  endtask

  // Status counters refuse writes; the preset accepts only 1 to 16.
  task automatic t_readonly();
    wb(1'b1, OFF_STEP, 32'h0000_0009);
    wb(1'b1, OFF_CNT, 32'h0000_0005);
    rd_chk("step ro", OFF_STEP, 32'h0000_0001);
    rd_chk("count ro", OFF_CNT, 32'h0000_0000);
    wb(1'b1, OFF_PRE, 32'h0000_0011);
    rd_chk("preset 17", OFF_PRE, 32'h0000_0001);
    wb(1'b1, OFF_PRE, 32'h0000_0004);
    rd_chk("preset 4", OFF_PRE, 32'h0000_0004);
  endtask

  // Range limits of timebase, counts-per-step and base, and the read-only timer counter.
  task automatic t_limits();
    wb(1'b1, OFF_TB, 32'h0000_2710);
    rd_chk("tb 10000", OFF_TB, 32'h0000_0000);
    wb(1'b1, OFF_TB, 32'h0000_270f);
    rd_chk("tb 9999", OFF_TB, 32'h0000_270f);
    wb(1'b1, 9'h040, 32'h0000_2710);
    rd_chk("cps 10000", 9'h040, 32'h0000_0000);
    wb(1'b1, OFF_BASE, 32'h0000_007d);
    rd_chk("base 125", OFF_BASE, 32'h0000_0000);
    wb(1'b1, OFF_BASE, 32'h0000_007c);
    rd_chk("base 124", OFF_BASE, 32'h0000_007c);
    wb(1'b1, OFF_TMR, 32'h0000_0003);
    rd_chk("timer ro", OFF_TMR, 32'h0000_0000);
  endtask

  // Run entry, jog, masking and the word view of the outputs.
  task automatic t_run_jog();
    wb(1'b1, 9'h090, 32'h0000_a5a5);
    wb(1'b1, 9'h0d0, 32'h0000_0ff0);
    wb(1'b1, OFF_CTRL, 32'h0000_0018);
    rd_chk("run step", OFF_STEP, 32'h0000_0004);
    wb(1'b1, OFF_CTRL, 32'h0000_001a);
    wb(1'b1, OFF_CTRL, 32'h0000_0018);
    rd_chk("jog step", OFF_STEP, 32'h0000_0005);
    chk("masked out", 32'h0000_05a0, {16'h0000, drum_out});
    rd_chk("out word", OFF_OUT, 32'h0000_05a0);
    wb(1'b1, OFF_CTRL, 32'h0000_0008);
    wb(1'b1, OFF_CTRL, 32'h0000_0018);
    wb(1'b1, OFF_CTRL, 32'h0000_0008);
    repeat (3) @(posedge ref_clk);
    chk("plain out", 32'h0000_a5a5, {16'h0000, drum_out});
    wb(1'b1, OFF_CTRL, 32'h0000_0018);
    repeat (20) @(posedge ref_clk);
    rd_chk("no start", OFF_STEP, 32'h0000_0005);
    wb(1'b1, 9'h0d0, 32'h0000_0000);
    repeat (2) @(posedge ref_clk);
    chk("mask zero", 32'h0000_0000, {16'h0000, drum_out});
  endtask

  // Event gating, completion, hold and reset.
  task automatic t_event();
    int n;
    n = 0;
    wb(1'b1, 9'h110, 32'h0000_0012);
    wb(1'b1, 9'h050, 32'h0000_0002);
    wb(1'b1, OFF_TB, 32'h0000_0001);
    wb(1'b1, OFF_CTRL, 32'h0000_0019);
    repeat (40) @(posedge ref_clk);
    rd_chk("ev low", OFF_STEP, 32'h0000_0005);
    ev_req <= 16'h0004;
    rd_chk("ev early", OFF_STEP, 32'h0000_0005);
    q = 32'h0000_0000;
    while (q[31] !== 1'b1 && n < 100) begin
      wb(1'b0, OFF_CNT, 32'h0000_0000);
      n = n + 1;
    end
    chk("done", 32'h0000_0001, {31'h0, q[31]});
    rd_chk("last step", OFF_STEP, 32'h0000_0010);
    repeat (20) @(posedge ref_clk);
    rd_chk("hold step", OFF_STEP, 32'h0000_0010);
    rd_chk("hold done", OFF_CNT, 32'h8000_0000);
    wb(1'b1, OFF_PRE, 32'h0000_0002);
    wb(1'b1, OFF_CTRL, 32'h0000_001d);
    rd_chk("clr done", OFF_CNT, 32'h0000_0000);
    rd_chk("rst step", OFF_STEP, 32'h0000_0002);
    chk("rst out", 32'h0000_0000, {16'h0000, drum_out});
  endtask

  // Main sequence.
  initial begin
    nrst      = 1'b0;
    wb_cyc_i  = 1'b0;
    wb_stb_i  = 1'b0;
    wb_we_i   = 1'b0;
    wb_adr_i  = 9'h000;
    wb_sel_i  = 4'hf;
    wb_dat_i  = 32'h0000_0000;
    ev_req    = 16'h0000;
    err_total = 0;
    compares  = 0;
    cycles    = 0;
    repeat (10) @(posedge ref_clk);
    nrst <= 1'b1;
    t_reset_vals();
    t_readonly();
    t_limits();
    t_run_jog();
    t_event();
    finish_test();
  end
endmodule
